// ### bench/adc_seq_asserts.sv
`timescale 1ns/1ps
// ======
// Port checks
module adc_seq_asserts
  import adc_seq_pkg::*;
#(
  parameter int RES_W = 12
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sample_trigger_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic word_mode,
  input wire logic [CTRL_W-1:0] data_oe,
  input wire logic busy,
  input wire logic ref_ext_sel,
  input wire logic [CHAN_W-1:0] conv_channel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  trig_busy_a: assert property ($fell(sample_trigger_n) && !busy |-> ##[1:4] busy)
    else $error("busy missed trigger");
  busy_hold_a: assert property ($rose(busy) |-> ##60 busy)
    else $error("busy fell early");
  oe_read_a: assert property (|data_oe |-> !$past(cs_n, 3) && !$past(rd_n, 3))
    else $error("lines driven outside read");
  oe_release_a: assert property ($rose(rd_n) |-> ##[1:4] data_oe == 12'h0)
    else $error("lines not released");
  word_lines_a: assert property (|data_oe && word_mode |-> &data_oe[RES_W-1:0])
    else $error("word read not full width");
  byte_lines_a: assert property (|data_oe && !word_mode |-> data_oe == 12'h0ff)
    else $error("byte read width wrong");
  ref_write_a: assert property ($changed(ref_ext_sel) |-> wr_n && $past(wr_n))
    else $error("reference changed mid write");
  chan_start_a: assert property ($changed(conv_channel) |-> $rose(busy))
    else $error("channel moved outside start");
  cover property ($fell(busy));
  cover property (|data_oe && !word_mode);
  cover property ($rose(busy) && conv_channel == 2'h3);
endmodule

bind adc_sequencer_parallel_port adc_seq_asserts #(.RES_W(RES_W)) asserts_i (
  .mclk, .rst_b, .sample_trigger_n, .cs_n, .rd_n, .wr_n, .word_mode, .data_oe, .busy,
  .ref_ext_sel, .conv_channel);

// ### bench/adc_sequencer_parallel_port_tb.sv
`timescale 1ns/1ps
// ======
// Bench
module adc_sequencer_parallel_port_tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic trig_n = 1'b1;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic word_mode = 1'b1;
  logic [11:0] hdata = 12'h0;
  logic [11:0] hoe = 12'h0;
  logic [11:0] core_result = 12'h0;
  logic [11:0] bus, data_out, data_oe, v;
  logic busy, ref_ext_sel, powered_up, pw;
  logic [1:0] conv_channel;
  int errors = 0;
  int comparisons = 0;
  always #5 mclk = ~mclk;
  adc_sequencer_parallel_port #(.RES_W(12)) dut (.mclk, .rst_b, .sample_trigger_n(trig_n),
    .cs_n, .rd_n, .wr_n, .word_mode, .data_in(bus), .core_result, .data_out, .data_oe,
    .busy, .ref_ext_sel, .conv_channel, .powered_up);
  host_bus_model host (.mclk, .rst_b, .dev_data(data_out), .dev_oe(data_oe),
    .host_data(hdata), .host_oe(hoe), .bus);
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr1(input logic [11:0] d);
    @(negedge mclk);
    hdata = d;
    hoe = 12'hfff;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (3) @(negedge mclk);
    wr_n = 1'b1;
    cs_n = 1'b1;
    repeat (6) @(negedge mclk);
    hoe = 12'h0;
  endtask
  task automatic wr(input logic [11:0] d);
    if (word_mode === 1'b1) begin
      wr1(d);
    end else begin
      wr1({4'h0, d[7:0]});
      wr1({4'h1, 4'h0, d[11:8]});
    end
  endtask
  task automatic rd(input logic hb, output logic [11:0] d);
    @(negedge mclk);
    hdata = {3'h0, hb, 8'h0};
    hoe = word_mode ? 12'h0 : 12'h100;
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (5) @(negedge mclk);
    d = bus;
    rd_n = 1'b1;
    cs_n = 1'b1;
    repeat (5) @(negedge mclk);
    hoe = 12'h0;
    chk(data_oe, 12'h0);
  endtask
  task automatic tg();
    @(negedge mclk);
    trig_n = 1'b0;
    repeat (4) @(negedge mclk);
    trig_n = 1'b1;
    repeat (5) @(negedge mclk);
    pw = powered_up;
  endtask
  task automatic cv(input logic [11:0] r);
    core_result = r;
    tg();
    chk({11'h0, busy}, 12'h1);
    for (int n = 0; n < 100 && busy !== 1'b0; n++) begin
      @(negedge mclk);
    end
    chk({11'h0, busy}, 12'h0);
  endtask
  task automatic cvr(input logic [11:0] r, input logic [1:0] ch);
    cv(r);
    chk({10'h0, conv_channel}, {10'h0, ch});
    rd(1'b0, v);
    if (word_mode === 1'b1) begin
      chk(v, r);
    end else begin
      chk({4'h0, v[7:0]}, {4'h0, r[7:0]});
      rd(1'b1, v);
      chk({4'h0, v[7:0]}, {6'h0, ch, r[11:8]});
    end
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    chk({7'h0, busy, ref_ext_sel, powered_up, conv_channel}, 12'h004);
    wr(12'hca0);
    chk({11'h0, ref_ext_sel}, 12'h1);
    cvr(12'h5a3, 2'h2);
    cvr(12'h2c1, 2'h2);
    word_mode = 1'b0;
    wr(12'hf80);
    chk({11'h0, ref_ext_sel}, 12'h0);
    for (int i = 0; i < 5; i++) begin
      cvr(12'(12'h3c5 + 12'h111 * i), 2'(i % 3));
    end
    wr(12'hee0);
    chk({11'h0, ref_ext_sel}, 12'h1);
    cvr(12'h7e2, 2'h2);
    cvr(12'h7e3, 2'h3);
    cvr(12'h7e4, 2'h0);
    for (int o = 0; o < 2; o++) begin
      wr(12'hf80);
      cvr(12'h0ab, 2'h0);
      wr(12'(12'hc40 + 12'h100 * o));
      cvr(12'h0cd, 2'h1);
      cvr(12'h0ef, 2'h1);
    end
    word_mode = 1'b1;
    wr(12'h400);
    cvr(12'h111, 2'h0);
    chk({11'h0, powered_up}, 12'h0);
    cvr(12'h222, 2'h0);
    chk({11'h0, pw}, 12'h1);
    wr(12'hc00);
    cvr(12'h333, 2'h0);
    chk({11'h0, powered_up}, 12'h1);
    wr(12'h800);
    chk({11'h0, powered_up}, 12'h0);
    cvr(12'h444, 2'h0);
    chk({11'h0, pw}, 12'h0);
    wr(12'hc00);
    for (int i = 0; i < 16; i++) begin
      cv(12'(12'h0a0 + i));
    end
    core_result = 12'h0b0;
    tg();
    repeat (80) @(negedge mclk);
    chk({11'h0, busy}, 12'h1);
    for (int i = 0; i < 17; i++) begin
      rd(1'b0, v);
      chk(v, 12'(12'h0a0 + i));
    end
    rd(1'b0, v);
    chk(v, 12'h0);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    tally_and_finish();
  end
endmodule

// ### bench/host_bus_model.sv
`timescale 1ns/1ps
// ======
// Data line resolution; no pull, so a released line toggles
module host_bus_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [11:0] dev_data,
  input wire logic [11:0] dev_oe,
  input wire logic [11:0] host_data,
  input wire logic [11:0] host_oe,
  output logic [11:0] bus
);
  logic [11:0] last_q;
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (dev_oe[i]) begin
        bus[i] = dev_data[i];
      end else if (host_oe[i]) begin
        bus[i] = host_data[i];
      end else begin
        bus[i] = ~last_q[i];
      end
    end
  end
  always_ff @(posedge mclk) begin
    last_q <= rst_b ? bus : 12'h0;
  end
endmodule

// ### src/adc_seq_pkg.sv
package adc_seq_pkg;

  // ==========================================================
  // Control word layout
  localparam int CTRL_W = 12;
  localparam int POS_PM_HI = 11;
  localparam int POS_PM_LO = 10;
  localparam int POS_ORDER_HI = 9;
  localparam int POS_ORDER_LO = 8;
  localparam int POS_SEL_HI = 7;
  localparam int POS_SEL_LO = 6;
  localparam int POS_REF = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'hc00;

  // ==========================================================
  // Field codes
  localparam logic [1:0] ORDER_CONSEC = 2'h3;
  localparam logic [1:0] ORDER_KEEP = 2'h2;
  localparam logic [1:0] PM_FULL_SD = 2'h2;

  // ==========================================================
  // Port geometry
  localparam int BYTE_W = 8;
  localparam int UBE_POS = 8;
  localparam int CHAN_W = 2;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 600;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_PUSH
  } conv_state_t;

endpackage

// ### src/adc_sequencer_parallel_port.sv
`timescale 1ns/1ps
module adc_sequencer_parallel_port
  import adc_seq_pkg::*;
#(
  parameter int RES_W = 12,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sample_trigger_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic word_mode,
  input wire logic [CTRL_W-1:0] data_in,
  input wire logic [RES_W-1:0] core_result,
  output logic [CTRL_W-1:0] data_out,
  output logic [CTRL_W-1:0] data_oe,
  output logic busy,
  output logic ref_ext_sel,
  output logic [CHAN_W-1:0] conv_channel,
  output logic powered_up
);

  localparam int ENTRY_W = RES_W + CHAN_W;

  // ==========================================================
  // Control word fields
  function automatic logic [1:0] order_of(input logic [CTRL_W-1:0] w);
    return w[POS_ORDER_HI:POS_ORDER_LO];
  endfunction

  function automatic logic [CHAN_W-1:0] sel_of(input logic [CTRL_W-1:0] w);
    return w[POS_SEL_HI:POS_SEL_LO];
  endfunction

  function automatic logic [1:0] pm_of(input logic [CTRL_W-1:0] w);
    return w[POS_PM_HI:POS_PM_LO];
  endfunction

  // ==========================================================
  // Pin synchronisers
  // Idle levels at reset keep a spurious edge from firing.
  logic [4:0] pins_s;
  logic [CTRL_W-1:0] data_s;
  logic trig_s, cs_s, rd_s, wr_s, word_s;

  pin_sync #(
    .WIDTH(5),
    .RST_VAL(5'h1e)
  ) u_pin_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d({sample_trigger_n, cs_n, rd_n, wr_n, word_mode}),
    .q(pins_s)
  );

  pin_sync #(
    .WIDTH(CTRL_W),
    .RST_VAL('0)
  ) u_data_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d(data_in),
    .q(data_s)
  );

  assign trig_s = pins_s[4];
  assign cs_s = pins_s[3];
  assign rd_s = pins_s[2];
  assign wr_s = pins_s[1];
  assign word_s = pins_s[0];

  // ==========================================================
  // Result buffer
  result_fifo_if #(.WIDTH(ENTRY_W)) fifo_bus ();

  result_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .port(fifo_bus.store)
  );

  // ==========================================================
  // Edge history
  logic trig_prev_q, trig_prev_d;
  logic wr_prev_q, wr_prev_d;
  logic cs_prev_q, cs_prev_d;
  logic rd_act_prev_q, rd_act_prev_d;
  logic trig_fall, trig_rise, wr_take, rd_act, rd_end;

  always_comb begin
    trig_prev_d = rst_b ? trig_s : 1'b1;
    wr_prev_d = rst_b ? wr_s : 1'b1;
    cs_prev_d = rst_b ? cs_s : 1'b1;
    rd_act_prev_d = rst_b ? rd_act : 1'b0;
  end

  always_ff @(posedge mclk) begin
    trig_prev_q <= trig_prev_d;
    wr_prev_q <= wr_prev_d;
    cs_prev_q <= cs_prev_d;
    rd_act_prev_q <= rd_act_prev_d;
  end

  assign trig_fall = trig_prev_q && !trig_s;
  assign trig_rise = !trig_prev_q && trig_s;
  // Select is judged before the edge so tied strobes still write.
  assign wr_take = !wr_prev_q && wr_s && !cs_prev_q;
  assign rd_act = !cs_s && !rd_s;
  assign rd_end = rd_act_prev_q && !rd_act;

  // ==========================================================
  // Control register and sequencer
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [BYTE_W-1:0] low_byte_q, low_byte_d;
  logic seq_on_q, seq_on_d;
  logic [CHAN_W-1:0] next_chan_q, next_chan_d;
  logic [CTRL_W-1:0] wr_word;
  logic commit;
  logic conv_done;
  logic [1:0] new_order;
  logic [CHAN_W-1:0] new_sel, last_sel;

  always_comb begin
    ctrl_d = ctrl_q;
    low_byte_d = low_byte_q;
    seq_on_d = seq_on_q;
    next_chan_d = next_chan_q;
    commit = 1'b0;
    wr_word = ctrl_q;
    last_sel = sel_of(ctrl_q);
    if (conv_done && seq_on_q) begin
      if (conv_channel == last_sel) begin
        next_chan_d = '0;
      end else begin
        next_chan_d = CHAN_W'(conv_channel + 1'b1);
      end
    end
    if (wr_take) begin
      if (word_s) begin
        wr_word = data_s;
        commit = 1'b1;
      end else if (!data_s[UBE_POS]) begin
        low_byte_d = data_s[BYTE_W-1:0];
      end else begin
        wr_word = {data_s[CTRL_W-BYTE_W-1:0], low_byte_q};
        commit = 1'b1;
      end
    end
    new_order = order_of(wr_word);
    new_sel = sel_of(wr_word);
    if (commit) begin
      ctrl_d = wr_word;
      if (new_order == ORDER_CONSEC) begin
        seq_on_d = 1'b1;
        next_chan_d = '0;
      end else if (new_order == ORDER_KEEP) begin
        // Mid-sequence rewrite keeps the run going.
        if (!seq_on_q) begin
          next_chan_d = new_sel;
        end
      end else begin
        seq_on_d = 1'b0;
        next_chan_d = new_sel;
      end
    end
    if (!rst_b) begin
      ctrl_d = CTRL_RST;
      low_byte_d = '0;
      seq_on_d = 1'b0;
      next_chan_d = '0;
    end
  end

  always_ff @(posedge mclk) begin
    ctrl_q <= ctrl_d;
    low_byte_q <= low_byte_d;
    seq_on_q <= seq_on_d;
    next_chan_q <= next_chan_d;
  end

  assign ref_ext_sel = ctrl_q[POS_REF];

  // ==========================================================
  // Conversion timing and power
  conv_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic busy_d;
  logic [CHAN_W-1:0] conv_chan_d;
  logic [RES_W-1:0] result_q, result_d;
  logic powered_d;
  logic [1:0] pm;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    busy_d = busy;
    conv_chan_d = conv_channel;
    result_d = result_q;
    powered_d = powered_up;
    conv_done = 1'b0;
    pm = pm_of(ctrl_q);
    case (state_q)
      ST_IDLE: begin
        // Further falling edges while busy are ignored.
        if (trig_fall) begin
          state_d = ST_CONV;
          busy_d = 1'b1;
          cnt_d = '0;
          conv_chan_d = next_chan_q;
        end
      end
      ST_CONV: begin
        if (cnt_q == CNT_W'(CONV_CYCLES - 1)) begin
          state_d = ST_PUSH;
          result_d = core_result;
        end else begin
          cnt_d = CNT_W'(cnt_q + 1'b1);
        end
      end
      ST_PUSH: begin
        // A full buffer stretches busy until the host drains it.
        if (fifo_bus.push_ready) begin
          state_d = ST_IDLE;
          busy_d = 1'b0;
          conv_done = 1'b1;
          if (!pm[1]) begin
            powered_d = 1'b0;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // A wake edge beats the end-of-conversion power-down.
    if (trig_rise && pm != PM_FULL_SD) begin
      powered_d = 1'b1;
    end
    if (commit && pm_of(wr_word) == PM_FULL_SD) begin
      powered_d = 1'b0;
    end
    if (!rst_b) begin
      state_d = ST_IDLE;
      cnt_d = '0;
      busy_d = 1'b0;
      conv_chan_d = '0;
      result_d = '0;
      powered_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    state_q <= state_d;
    cnt_q <= cnt_d;
    busy <= busy_d;
    conv_channel <= conv_chan_d;
    result_q <= result_d;
    powered_up <= powered_d;
  end

  assign fifo_bus.push_valid = (state_q == ST_PUSH);
  // Channel travels with its result, so a backlog cannot mislabel it.
  assign fifo_bus.push_data = {conv_channel, result_q};

  // ==========================================================
  // Read port
  logic [CTRL_W-1:0] data_out_d, data_oe_d;
  logic ube_q, ube_d;
  logic [RES_W-1:0] head_res;
  logic [CHAN_W-1:0] head_chan;
  logic [BYTE_W-1:0] hi_byte;
  logic pop;

  always_comb begin
    // Empty buffer reads as zero, never as stale data.
    head_res = fifo_bus.pop_valid ? fifo_bus.pop_data[RES_W-1:0] : '0;
    head_chan = fifo_bus.pop_valid ? fifo_bus.pop_data[ENTRY_W-1:RES_W] : '0;
    // MSBs in the low lines, channel number just above them.
    hi_byte = BYTE_W'(head_res >> BYTE_W)
            | BYTE_W'({head_chan, {(RES_W-BYTE_W){1'b0}}});
    data_out_d = data_out;
    data_oe_d = '0;
    ube_d = ube_q;
    pop = 1'b0;
    if (rd_act) begin
      if (word_s) begin
        data_out_d = CTRL_W'(head_res);
        data_oe_d = CTRL_W'({RES_W{1'b1}});
      end else begin
        ube_d = data_s[UBE_POS];
        data_out_d = CTRL_W'(data_s[UBE_POS] ? hi_byte
                                             : head_res[BYTE_W-1:0]);
        data_oe_d = CTRL_W'({BYTE_W{1'b1}});
      end
    end
    // Advance only once the whole result has been fetched.
    if (rd_end && (word_s || ube_q)) begin
      pop = 1'b1;
    end
    if (!rst_b) begin
      data_out_d = '0;
      data_oe_d = '0;
      ube_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    data_out <= data_out_d;
    data_oe <= data_oe_d;
    ube_q <= ube_d;
  end

  assign fifo_bus.pop_ready = pop;

endmodule

// ### src/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] q_d;

  always_comb begin
    meta_d = rst_b ? d : RST_VAL;
    q_d = rst_b ? meta_q : RST_VAL;
  end

  always_ff @(posedge mclk) begin
    meta_q <= meta_d;
    q <= q_d;
  end
endmodule

// ### src/result_fifo.sv
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  result_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  always_comb begin
    do_push = port.push_valid && port.push_ready;
    do_pop = port.pop_valid && port.pop_ready;
    wr_d = do_push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d = do_pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (do_push && !do_pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (do_pop && !do_push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
    if (!rst_b) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge mclk) begin
    wr_q <= wr_d;
    rd_q <= rd_d;
    cnt_q <= cnt_d;
    if (do_push) begin
      mem_q[wr_q] <= port.push_data;
    end
  end

  assign port.push_ready = (cnt_q != (AW+1)'(DEPTH));
  assign port.pop_valid = (cnt_q != '0);
  assign port.pop_data = mem_q[rd_q];
endmodule

// ### src/result_fifo_if.sv
`timescale 1ns/1ps
interface result_fifo_if #(
  parameter int WIDTH = 14
);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport filler (output push_valid, push_data, input push_ready,
                  input pop_valid, pop_data, output pop_ready);
  modport store (input push_valid, push_data, output push_ready,
                 output pop_valid, pop_data, input pop_ready);
endinterface
